// *** acx_pkg.sv ***
package acx_pkg;
   // ****************************************************************
   // widths and constants
   // ****************************************************************
   localparam int DATA_W = 8;   // data path width
   localparam int ADDR_W = 8;   // data memory address width
   localparam int PC_W = 12;    // program counter width
   localparam int BIT_W = 3;    // bit select width
   localparam int DEPTH = 160;  // data memory bytes
   localparam int WDT_W = 16;   // watchdog counter width
   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [PC_W-1:0] PC_STEP = 12'h001;
   localparam logic [PC_W-1:0] PC_RESET = 12'h000;
   localparam logic [WDT_W-1:0] WDT_ZERO = 16'h0000;
   localparam logic [WDT_W-1:0] WDT_STEP = 16'h0001;

   // ****************************************************************
   // operations handled by this block
   // ****************************************************************
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_AND_MEM = 4'h1,
      OP_AND_IMM = 4'h2,
      OP_AND_INTO_MEM = 4'h3,
      OP_CALL = 4'h4,
      OP_ZERO_FILL = 4'h5,
      OP_ZERO_FILL_BIT = 4'h6,
      OP_BITWISE_INVERT = 4'h7,
      OP_WATCHDOG_RESTART = 4'h8,
      OP_WATCHDOG_PRECLEAR_FIRST = 4'h9,
      OP_WATCHDOG_PRECLEAR_SECOND = 4'ha
   } acx_op_e;

   // preclear pairing state, one-hot
   typedef enum logic [2:0] {
      PC_IDLE = 3'b001,
      PC_GOT_FIRST = 3'b010,
      PC_GOT_SECOND = 3'b100
   } acx_pre_e;

   // one decoded instruction
   typedef struct packed {
      logic valid;
      acx_op_e op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] imm;
      logic [BIT_W-1:0] bit_sel;
      logic [PC_W-1:0] target;
   } acx_instr_s;

   // status flags
   typedef struct packed {
      logic timeout_flag;
      logic power_down_flag;
      logic zero;
      logic carry;
      logic aux_carry;
      logic overflow;
   } acx_flags_s;
endpackage

// *** acx_exec.sv ***
`timescale 1ns/1ps
module acx_exec
   import acx_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire acx_instr_s instr,
   input wire logic wdt_timeout,
   input wire logic power_down,
   input wire logic [DATA_W-1:0] acc_load,
   input wire logic acc_load_en,
   output logic [DATA_W-1:0] acc,
   output acx_flags_s flags,
   output logic [PC_W-1:0] pc,
   output logic [PC_W-1:0] stack_top,
   output logic push_pulse,
   output logic [WDT_W-1:0] watchdog_counter,
   output logic mem_we,
   output logic [ADDR_W-1:0] mem_waddr,
   output logic [DATA_W-1:0] mem_wdata
);
   // ****************************************************************
   // data memory and execution state
   // ****************************************************************
   // the byte array has no reset, so software must fill it before use
   logic [DATA_W-1:0] mem_q [DEPTH];   // data bytes
   logic [DATA_W-1:0] acc_q, acc_d;    // working register
   acx_flags_s flags_q, flags_d;       // status flags
   logic [PC_W-1:0] pc_q, pc_d;        // program counter
   logic [PC_W-1:0] stk_q, stk_d;      // last pushed return address
   logic push_q, push_d;               // push strobe
   logic [WDT_W-1:0] wdt_q, wdt_d;     // watchdog counter
   acx_pre_e pre_q, pre_d;             // preclear pairing
   logic we_q, we_d;                   // memory write strobe
   logic [ADDR_W-1:0] wa_q, wa_d;      // memory write address
   logic [DATA_W-1:0] wd_q, wd_d;      // memory write data
   logic [DATA_W-1:0] rd;              // operand byte read
   logic [DATA_W-1:0] bit_mask;        // one-hot bit select
   logic wdt_clear;                    // watchdog cleared this cycle

   // out-of-range addresses read as zero rather than index past the array
   assign rd = (instr.addr < DEPTH) ? mem_q[instr.addr] : BYTE_ZERO;

   // per-bit select mask
   // one compare per bit keeps it flat, no barrel shifter needed
   generate
      for (genvar i = 0; i < DATA_W; i++) begin : g_mask
         assign bit_mask[i] = (instr.bit_sel == BIT_W'(i));
      end
   endgenerate

   // ****************************************************************
   // next-state computation
   // ****************************************************************
   always_comb begin
      // defaults: hold state, step the pc, run the watchdog, strobes low
      // strobes fall back to low here so each lasts one cycle
      acc_d = acc_q;
      flags_d = flags_q;
      pc_d = pc_q + PC_STEP;
      stk_d = stk_q;
      push_d = 1'b0;
      wdt_d = wdt_q + WDT_STEP;
      pre_d = pre_q;
      we_d = 1'b0;
      wa_d = instr.addr;
      wd_d = BYTE_ZERO;
      wdt_clear = 1'b0;
      // outside events from the watchdog and halt logic, and the working register preload
      if (wdt_timeout) begin
         flags_d.timeout_flag = 1'b1;
      end
      if (power_down) begin
         flags_d.power_down_flag = 1'b1;
      end
      if (acc_load_en) begin
         acc_d = acc_load;
      end
      // an idle slot holds pc and strobes nothing; watchdog, outside events and the write address still move
      if (!instr.valid) begin
         pc_d = pc_q;   // no instruction, hold the counter
      end else begin
         unique case (instr.op)
            // and with a data byte, result into the working register
            OP_AND_MEM: begin
               acc_d = acc_q & rd;
               flags_d.zero = ((acc_q & rd) == BYTE_ZERO);
            end
            // and with the immediate carried in the instruction
            OP_AND_IMM: begin
               acc_d = acc_q & instr.imm;
               flags_d.zero = ((acc_q & instr.imm) == BYTE_ZERO);
            end
            // and result goes back to memory, working register kept
            OP_AND_INTO_MEM: begin
               we_d = 1'b1;
               wd_d = acc_q & rd;
               flags_d.zero = ((acc_q & rd) == BYTE_ZERO);
            end
            // push the return address, then jump whatever the flags
            OP_CALL: begin
               stk_d = pc_q + PC_STEP;
               push_d = 1'b1;
               pc_d = instr.target;
            end
            // whole byte to zero, no flag moves
            OP_ZERO_FILL: begin
               we_d = 1'b1;
               wd_d = BYTE_ZERO;
            end
            // read-modify-write of one bit, the other seven kept
            OP_ZERO_FILL_BIT: begin
               we_d = 1'b1;
               wd_d = rd & ~bit_mask;
            end
            // complement in place, zero flag follows the result
            OP_BITWISE_INVERT: begin
               we_d = 1'b1;
               wd_d = ~rd;
               flags_d.zero = (~rd == BYTE_ZERO);
            end
            // single restart also forgets any half-done preclear pair
            OP_WATCHDOG_RESTART: begin
               wdt_clear = 1'b1;
               pre_d = PC_IDLE;
            end
            // first of a preclear pair
            OP_WATCHDOG_PRECLEAR_FIRST: begin
               // only the alternate partner completes the pair
               if (pre_q == PC_GOT_SECOND) begin
                  wdt_clear = 1'b1;
                  pre_d = PC_IDLE;
               end else begin
                  pre_d = PC_GOT_FIRST;
               end
            end
            // second of a preclear pair
            OP_WATCHDOG_PRECLEAR_SECOND: begin
               // a repeat of the same half only restarts the pairing
               if (pre_q == PC_GOT_FIRST) begin
                  wdt_clear = 1'b1;
                  pre_d = PC_IDLE;
               end else begin
                  pre_d = PC_GOT_SECOND;
               end
            end
            default: begin
            end
         endcase
      end
      // a clear by instruction overrides a coincident timeout event
      if (wdt_clear) begin
         wdt_d = WDT_ZERO;
         flags_d.timeout_flag = 1'b0;
         flags_d.power_down_flag = 1'b0;
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   // sync reset; otherwise every register just loads its next value
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         acc_q <= BYTE_ZERO;
         flags_q <= '0;
         pc_q <= PC_RESET;
         stk_q <= PC_RESET;
         push_q <= 1'b0;
         wdt_q <= WDT_ZERO;
         pre_q <= PC_IDLE;
         we_q <= 1'b0;
         wa_q <= '0;
         wd_q <= BYTE_ZERO;
      end else begin
         acc_q <= acc_d;
         flags_q <= flags_d;
         pc_q <= pc_d;
         stk_q <= stk_d;
         push_q <= push_d;
         wdt_q <= wdt_d;
         pre_q <= pre_d;
         we_q <= we_d;
         wa_q <= wa_d;
         wd_q <= wd_d;
      end
   end

   // memory array, no reset so it maps onto plain storage
   // a write past the array is dropped, the strobe still echoes
   always_ff @(posedge sys_clk) begin
      if (!rst && we_d && instr.addr < DEPTH) begin
         mem_q[instr.addr] <= wd_d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // every output is a register, no logic sits after the flip-flops
   assign acc = acc_q;
   assign flags = flags_q;
   assign pc = pc_q;
   assign stack_top = stk_q;
   assign push_pulse = push_q;
   assign watchdog_counter = wdt_q;
   assign mem_we = we_q;
   assign mem_waddr = wa_q;
   assign mem_wdata = wd_q;
endmodule

// *** acx_sva.sv ***
`timescale 1ns/1ps
// ****************************************************************
// port checker for the execution block
// ****************************************************************
module acx_sva
   import acx_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire acx_instr_s instr,
   input wire logic [DATA_W-1:0] acc_load,
   input wire logic acc_load_en,
   input wire logic [DATA_W-1:0] acc,
   input wire acx_flags_s flags,
   input wire logic [PC_W-1:0] pc,
   input wire logic [PC_W-1:0] stack_top,
   input wire logic push_pulse,
   input wire logic [WDT_W-1:0] watchdog_counter,
   input wire logic mem_we,
   input wire logic [DATA_W-1:0] mem_wdata
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // a call pushes the next address and jumps in the same step
   property p_call;
      instr.valid && instr.op == OP_CALL |=> push_pulse &&
         stack_top == $past(pc) + PC_STEP && pc == $past(instr.target);
   endproperty
   a_call: assert property (p_call) else $error("call wrong");
   property p_seq;
      instr.valid && instr.op != OP_CALL |=> pc == $past(pc) + PC_STEP;
   endproperty
   a_seq: assert property (p_seq) else $error("pc step wrong");
   property p_hold;
      !instr.valid |=> $stable(pc) && !push_pulse && !mem_we;
   endproperty
   a_hold: assert property (p_hold) else $error("idle not idle");
   property p_imm;
      instr.valid && instr.op == OP_AND_IMM |=>
         acc == ($past(acc) & $past(instr.imm)) && flags.zero == (acc == 0);
   endproperty
   a_imm: assert property (p_imm) else $error("and imm wrong");
   // memory form must leave the working register alone
   property p_into;
      instr.valid && instr.op == OP_AND_INTO_MEM |=> mem_we &&
         acc == ($past(acc_load_en) ? $past(acc_load) : $past(acc)) &&
         flags.zero == (mem_wdata == BYTE_ZERO);
   endproperty
   a_into: assert property (p_into) else $error("and mem wrong");
   property p_fill;
      instr.valid && instr.op == OP_ZERO_FILL |=>
         mem_we && mem_wdata == BYTE_ZERO && $stable(flags.zero);
   endproperty
   a_fill: assert property (p_fill) else $error("fill wrong");
   property p_restart;
      instr.valid && instr.op == OP_WATCHDOG_RESTART |=>
         watchdog_counter == WDT_ZERO && !flags.timeout_flag &&
         !flags.power_down_flag;
   endproperty
   a_restart: assert property (p_restart) else $error("restart");
   // no instruction here may move the arithmetic flags
   property p_keep;
      1'b1 |=> $stable({flags.carry, flags.aux_carry, flags.overflow});
   endproperty
   a_keep: assert property (p_keep) else $error("flag moved");
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
fails++; $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb
   import acx_pkg::*;
;
   logic sys_clk, rst = 1, wdt_timeout = 0, power_down = 0;
   logic acc_load_en = 0, push_pulse, mem_we, c_to = 0, c_pd = 0, c_ld = 0;
   acx_instr_s instr = '0, cur = '0, ri;
   logic [DATA_W-1:0] acc_load = 8'h00, acc, mem_wdata, c_lv = 8'h00;
   logic [ADDR_W-1:0] mem_waddr;
   logic [PC_W-1:0] pc, stack_top;
   logic [WDT_W-1:0] watchdog_counter;
   acx_flags_s flags;
   int fails = 0, total_checks = 0;
   // model state: memory, acc, flags, pc, stack, watchdog, pairing
   int mem[DEPTH], a, z, to, pd, p, stk, ps, w, pre, we, wa, wd;
   acx_exec dut (.sys_clk, .rst, .instr, .wdt_timeout, .power_down,
      .acc_load, .acc_load_en, .acc, .flags, .pc, .stack_top, .push_pulse,
      .watchdog_counter, .mem_we, .mem_waddr, .mem_wdata);
   initial begin
      sys_clk = 0;
      forever #50 sys_clk = ~sys_clk;
   end
   // ****************************************************************
   // reference model, one call per taken edge
   // ****************************************************************
   task automatic model();
      int m, res, k, clr;
      k = cur.valid ? int'(cur.op) : 0;
      m = (cur.addr < DEPTH) ? mem[cur.addr] : 0;
      we = 0;
      ps = 0;
      clr = 0;
      case (k)
         1: begin a = a & m; z = a == 0; end
         2: begin a = a & cur.imm; z = a == 0; end
         3: begin res = a & m; z = res == 0; we = 1; end
         4: begin stk = (p + 1) % 4096; ps = 1; end
         5: begin res = 0; we = 1; end
         6: begin res = m & ~(1 << cur.bit_sel); we = 1; end
         7: begin res = ~m & 255; z = res == 0; we = 1; end
         8: begin clr = 1; pre = 0; end
         9: begin clr = pre == 2; pre = clr ? 0 : 1; end
         10: begin clr = pre == 1; pre = clr ? 0 : 2; end
      endcase
      // an instruction writing acc beats the preload
      if (c_ld && k != 1 && k != 2) a = c_lv;
      p = k == 4 ? cur.target : cur.valid ? (p + 1) % 4096 : p;
      if (we) begin
         wa = cur.addr;
         wd = res;
         if (cur.addr < DEPTH) mem[cur.addr] = res;
      end
      to = clr ? 0 : to | c_to;
      pd = clr ? 0 : pd | c_pd;
      w = clr ? 0 : (w + 1) % 65536;
   endtask
   task automatic check_all();
      `CHK("acc", a, acc)
      `CHK("zero", z, flags.zero)
      `CHK("keep", 0, {flags.carry, flags.aux_carry, flags.overflow})
      `CHK("pc", p, pc)
      `CHK("stack", stk, stack_top)
      `CHK("push", ps, push_pulse)
      `CHK("wdt", w, watchdog_counter)
      `CHK("to", to, flags.timeout_flag)
      `CHK("pd", pd, flags.power_down_flag)
      `CHK("we", we, mem_we)
      if (we) `CHK("wa", wa, mem_waddr)
      if (we) `CHK("wd", wd, mem_wdata)
   endtask
   // present one instruction, then judge the one taken at this edge
   task automatic step(acx_instr_s i);
      @(posedge sys_clk);
      instr <= i;
      wdt_timeout <= $urandom_range(15) == 0;
      power_down <= $urandom_range(15) == 0;
      acc_load_en <= $urandom_range(7) == 0;
      acc_load <= 8'($urandom);
      model();
      #1;
      check_all();
      cur = i;
      c_to = wdt_timeout;
      c_pd = power_down;
      c_ld = acc_load_en;
      c_lv = acc_load;
   endtask
   task automatic close_out();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h2b94_e389));
      repeat (2) @(posedge sys_clk);
      rst <= 0;
      // memory has no reset, so clear it all before any read
      for (int k = 0; k < DEPTH; k++)
         step('{1'b1, OP_ZERO_FILL, 8'(k), 8'h00, 3'h0, 12'h000});
      repeat (3000) begin
         ri = '{1'b1, acx_op_e'($urandom_range(10, 1)),
            8'($urandom_range(169)), 8'($urandom), 3'($urandom),
            12'($urandom)};
         ri.valid = $urandom_range(7) != 0;
         step(ri);
      end
      close_out();
   end
   initial begin
      #1000000;
      fails++;
      close_out();
   end
endmodule
bind acx_exec acx_sva u_sva (.*);
